// ---- core/bfs_top.sv ----
// boot flash startup sequencer: flash load, auto-init, boot status line
`timescale 1ns/1ns
// ------------------------------------------------------------
// Function
// - status line undriven while reset held
// - status line undriven until flash load finished
// - drive status high during auto-initialization
// - drive status low when init completes
// - accept commands/video only after init
// - auto-initialization begins after the flash load completes
// - init typically done within 1.76 s
// - flash addressing up to 16 MB
// - slow serial clock first, then fast
// - two chip selects, boot uses zero
// - copy code to memory, then auto-init
// - standard serial flash command protocol
// - single bit, mode 0, incrementing reads
// - launch and sample on falling edge
// - write enable, poll latch, clear protection
// ------------------------------------------------------------
module bfs_top #(
  parameter int BOOT_BYTES = bfs_pkg::BOOT_BYTES,
  parameter logic [23:0] BOOT_ADDR = bfs_pkg::BOOT_ADDR,
  parameter int INIT_CYCLES = bfs_pkg::INIT_CYCLES,
  parameter int SLOW_HALF = bfs_pkg::SLOW_HALF,
  parameter int FAST_HALF = bfs_pkg::FAST_HALF
)(
  // system
  input wire logic sys_clk,
  input wire logic nrst,
  // serial flash link
  output logic flash_clk,
  output logic flash_dout,
  input wire logic flash_din,
  output logic flash_select_zero_n,
  output logic flash_select_one_n,
  // boot status line, tri-state style: driven both high and low when enabled
  output logic boot_status_out,
  output logic boot_status_oe,
  // program memory read port for the processor
  input wire logic [15:0] pmem_raddr,
  output logic [7:0] pmem_rdata,
  // host side
  output logic host_accept,
  output logic boot_error
);
  localparam int MEM_AW = (BOOT_BYTES > 1) ? $clog2(BOOT_BYTES) : 1;
  localparam int CNT_W = 32;

  // ------------------------------------------------------------
  // input synchroniser
  // ------------------------------------------------------------
  logic din_meta_reg;
  logic din_sync_reg;
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      din_meta_reg <= 1'b0;
      din_sync_reg <= 1'b0;
    end
    else
    begin
      din_meta_reg <= flash_din;
      din_sync_reg <= din_meta_reg;
    end
  end

  // ------------------------------------------------------------
  // serial clock divider and shifter
  // ------------------------------------------------------------
  bfs_pkg::bfs_state_t state_reg;
  logic fast_reg;
  logic [15:0] div_reg;
  logic sclk_reg;
  logic busy_reg;
  logic start;
  logic [7:0] tx_byte;
  logic [7:0] tx_reg;
  logic [7:0] rx_reg;
  logic [3:0] bit_reg;
  logic byte_done;
  logic [1:0] cap_pipe_reg;
  logic [1:0] last_pipe_reg;
  logic [15:0] half_cnt;
  logic tick;

  assign half_cnt = fast_reg ? 16'(FAST_HALF - 1) : 16'(SLOW_HALF - 1);
  assign tick = busy_reg && (div_reg == half_cnt);

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      div_reg <= 16'h0000;
    else if (!busy_reg || tick)
      div_reg <= 16'h0000;
    else
      div_reg <= div_reg + 16'h0001;
  end

  // mode 0: idle low; data launched and sampled on the falling edge
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sclk_reg <= 1'b0;
      busy_reg <= 1'b0;
      tx_reg <= 8'h00;
      bit_reg <= 4'h0;
    end
    else
    begin
      if (start)
      begin
        busy_reg <= 1'b1;
        tx_reg <= tx_byte;
        bit_reg <= 4'h0;
        sclk_reg <= 1'b0;
      end
      else if (tick)
      begin
        sclk_reg <= ~sclk_reg;
        if (sclk_reg)
        begin
          // falling edge: launch next bit
          tx_reg <= {tx_reg[6:0], 1'b0};
          bit_reg <= bit_reg + 4'h1;
          if (bit_reg == 4'h7)
            busy_reg <= 1'b0;
        end
      end
    end
  end

  // din is two flops late; at the fast rate that is a whole bit, so
  // the falling-edge capture and the byte end wait two cycles
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cap_pipe_reg <= 2'h0;
      last_pipe_reg <= 2'h0;
      rx_reg <= 8'h00;
      byte_done <= 1'b0;
    end
    else
    begin
      cap_pipe_reg <= {cap_pipe_reg[0], tick && sclk_reg};
      last_pipe_reg <= {last_pipe_reg[0], tick && sclk_reg && (bit_reg == 4'h7)};
      byte_done <= last_pipe_reg[1];
      if (cap_pipe_reg[1])
        rx_reg <= {rx_reg[6:0], din_sync_reg};
    end
  end

  // ------------------------------------------------------------
  // boot sequencer
  // ------------------------------------------------------------
  logic cs_reg;
  logic [2:0] step_reg;
  logic [MEM_AW:0] count_reg;
  logic [CNT_W-1:0] init_reg;
  logic issued_reg;
  logic drive_reg;
  logic done_reg;
  logic [7:0] mem [0:BOOT_BYTES-1];

  assign start = (state_reg inside {bfs_pkg::ST_WRITE_ENABLE_COMMAND, bfs_pkg::ST_READ_STATUS_COMMAND, bfs_pkg::ST_WRSR,
                  bfs_pkg::ST_BUSY, bfs_pkg::ST_LOAD}) && !busy_reg && !issued_reg;

  // byte sent in each step of the current transaction
  always_comb
  begin
    tx_byte = bfs_pkg::ZERO_BYTE;
    case (state_reg)
      bfs_pkg::ST_WRITE_ENABLE_COMMAND: tx_byte = bfs_pkg::CMD_WRITE_ENABLE;
      bfs_pkg::ST_READ_STATUS_COMMAND, bfs_pkg::ST_BUSY: tx_byte = (step_reg == 3'd0) ? bfs_pkg::CMD_READ_STATUS
                                                                      : bfs_pkg::ZERO_BYTE;
      bfs_pkg::ST_WRSR: tx_byte = (step_reg == 3'd0) ? bfs_pkg::CMD_WRITE_STATUS : bfs_pkg::SR_UNPROTECT;
      bfs_pkg::ST_LOAD:
      begin
        case (step_reg)
          3'd0: tx_byte = bfs_pkg::CMD_FAST_READ;
          3'd1: tx_byte = BOOT_ADDR[23:16];
          3'd2: tx_byte = BOOT_ADDR[15:8];
          3'd3: tx_byte = BOOT_ADDR[7:0];
          default: tx_byte = bfs_pkg::ZERO_BYTE;
        endcase
      end
      default: tx_byte = bfs_pkg::ZERO_BYTE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_reg <= bfs_pkg::ST_RESET_WAIT;
      step_reg <= 3'd0;
      cs_reg <= 1'b0;
      issued_reg <= 1'b0;
      count_reg <= '0;
      fast_reg <= 1'b0;
      init_reg <= '0;
      boot_error <= 1'b0;
    end
    else
    begin
      if (start)
      begin
        issued_reg <= 1'b1;
        cs_reg <= 1'b1;
      end
      if (byte_done)
        issued_reg <= 1'b0;
      case (state_reg)
        bfs_pkg::ST_RESET_WAIT:
          state_reg <= bfs_pkg::ST_WRITE_ENABLE_COMMAND;
        bfs_pkg::ST_WRITE_ENABLE_COMMAND:
          if (byte_done)
          begin
            cs_reg <= 1'b0;
            step_reg <= 3'd0;
            state_reg <= bfs_pkg::ST_READ_STATUS_COMMAND;
          end
        bfs_pkg::ST_READ_STATUS_COMMAND, bfs_pkg::ST_BUSY:
          if (byte_done)
          begin
            if (step_reg == 3'd0)
              step_reg <= 3'd1;
            else
            begin
              cs_reg <= 1'b0;
              step_reg <= 3'd0;
              if (state_reg == bfs_pkg::ST_READ_STATUS_COMMAND && rx_reg[bfs_pkg::SR_WEL_BIT])
                state_reg <= bfs_pkg::ST_WRSR;
              else if (state_reg == bfs_pkg::ST_BUSY && !rx_reg[bfs_pkg::SR_WIP_BIT])
              begin
                fast_reg <= 1'b1;
                state_reg <= bfs_pkg::ST_LOAD;
              end
            end
          end
        bfs_pkg::ST_WRSR:
          if (byte_done)
          begin
            if (step_reg == 3'd0)
              step_reg <= 3'd1;
            else
            begin
              cs_reg <= 1'b0;
              step_reg <= 3'd0;
              state_reg <= bfs_pkg::ST_BUSY;
            end
          end
        bfs_pkg::ST_LOAD:
          if (byte_done)
          begin
            // command, three address bytes, one dummy, then data
            if (step_reg < 3'd5)
              step_reg <= step_reg + 3'd1;
            else if (count_reg == (MEM_AW + 1)'(BOOT_BYTES - 1))
            begin
              cs_reg <= 1'b0;
              state_reg <= bfs_pkg::ST_AUTOINIT;
            end
            else
              count_reg <= count_reg + 1'b1;
          end
        bfs_pkg::ST_AUTOINIT:
        begin
          init_reg <= init_reg + 1'b1;
          if (init_reg == CNT_W'(INIT_CYCLES - 1))
            state_reg <= bfs_pkg::ST_DONE;
        end
        bfs_pkg::ST_DONE:
          state_reg <= bfs_pkg::ST_DONE;
        default:
        begin
          boot_error <= 1'b1;
          state_reg <= bfs_pkg::ST_RESET_WAIT;
        end
      endcase
    end
  end

  // program memory fill, no reset needed on data
  always_ff @(posedge sys_clk)
  begin
    if (state_reg == bfs_pkg::ST_LOAD && byte_done && step_reg == 3'd5)
      mem[count_reg[MEM_AW-1:0]] <= rx_reg;
    pmem_rdata <= mem[pmem_raddr[MEM_AW-1:0]];
  end

  // ------------------------------------------------------------
  // boot status line
  // ------------------------------------------------------------
  // high is driven only once code is loaded; the pull-up covers the gap
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      drive_reg <= 1'b0;
      done_reg <= 1'b0;
    end
    else
    begin
      if (state_reg == bfs_pkg::ST_AUTOINIT)
        drive_reg <= 1'b1;
      if (state_reg == bfs_pkg::ST_DONE)
        done_reg <= 1'b1;
    end
  end

  assign boot_status_oe = drive_reg;
  assign boot_status_out = ~done_reg;
  assign host_accept = done_reg;

  // ------------------------------------------------------------
  // link outputs
  // ------------------------------------------------------------
  assign flash_clk = sclk_reg;
  assign flash_dout = tx_reg[7];
  assign flash_select_zero_n = ~cs_reg;
  assign flash_select_one_n = 1'b1;
endmodule : bfs_top

// ---- shared/bfs_pkg.sv ----
// constants for the boot flash startup sequencer
package bfs_pkg;
  localparam int CLK_HZ = 50_000_000;
  // serial clock rates, nominal
  localparam int SLOW_HZ = 1_420_000;
  localparam int FAST_HZ = 30_000_000;
  // half periods in system cycles, rounded down, at least one
  localparam int SLOW_HALF_RAW = CLK_HZ / (2 * SLOW_HZ);
  localparam int FAST_HALF_RAW = CLK_HZ / (2 * FAST_HZ);
  localparam int SLOW_HALF = (SLOW_HALF_RAW < 1) ? 1 : SLOW_HALF_RAW;
  localparam int FAST_HALF = (FAST_HALF_RAW < 1) ? 1 : FAST_HALF_RAW;
  // typical init time in ms, and its cycle count (rounded down)
  localparam int INIT_TIME_MS = 1760;
  localparam longint INIT_CYCLES_L = longint'(CLK_HZ) * INIT_TIME_MS / 1000;
  localparam int INIT_CYCLES = int'(INIT_CYCLES_L);
  // flash size limit: 128 Mbit = 16 MB, 24-bit byte address
  localparam int ADDR_W = 24;
  localparam int FLASH_BYTES = 16 * 1024 * 1024;
  // serial flash commands
  localparam logic [7:0] CMD_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] CMD_READ_STATUS = 8'h05;
  localparam logic [7:0] CMD_WRITE_STATUS = 8'h01;
  localparam logic [7:0] CMD_READ = 8'h03;
  localparam logic [7:0] CMD_FAST_READ = 8'h0b;
  // status bit positions and cleared value
  localparam int SR_WIP_BIT = 0;
  localparam int SR_WEL_BIT = 1;
  localparam logic [7:0] SR_UNPROTECT = 8'h00;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  // default boot image location and size
  localparam logic [23:0] BOOT_ADDR = 24'h000000;
  localparam int BOOT_BYTES = 1024;
  typedef enum {
    ST_RESET_WAIT,
    ST_WRITE_ENABLE_COMMAND,
    ST_READ_STATUS_COMMAND,
    ST_WRSR,
    ST_BUSY,
    ST_LOAD,
    ST_AUTOINIT,
    ST_DONE
  } bfs_state_t;
endpackage : bfs_pkg

// ---- test/bfs_checker.sv ----
// port checks for the boot flash startup sequencer
`timescale 1ns/1ns
module bfs_checker #(
  parameter int INIT_CYCLES = 50,
  parameter int SLOW_HALF = 17,
  parameter int FAST_HALF = 1
)(
  // system
  input wire logic sys_clk,
  input wire logic nrst,
  // flash link
  input wire logic flash_clk,
  input wire logic flash_dout,
  input wire logic flash_select_zero_n,
  input wire logic flash_select_one_n,
  // status and host
  input wire logic boot_status_out,
  input wire logic boot_status_oe,
  input wire logic host_accept
);
  int init_cnt_reg;
  int high_cnt_reg;
  // counts too long for a repetition live in helper logic
  always_ff @(posedge sys_clk or negedge nrst)
    if (!nrst)
      init_cnt_reg <= 0;
    else if (boot_status_oe && boot_status_out)
      init_cnt_reg <= init_cnt_reg + 1;
  always_ff @(posedge sys_clk or negedge nrst)
    if (!nrst)
      high_cnt_reg <= 0;
    else
      high_cnt_reg <= flash_clk ? high_cnt_reg + 1 : 0;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  sequence s_drive_start;
    $rose(boot_status_oe) ##0 boot_status_out;
  endsequence
  sequence s_done;
    boot_status_oe && !boot_status_out && host_accept;
  endsequence
  chk_quiet_after_reset: assert property ($rose(nrst) |-> !boot_status_oe)
    else $error("status driven at reset release");
  chk_released_loading: assert property (!flash_select_zero_n |-> !boot_status_oe)
    else $error("status driven during flash load");
  chk_high_while_init: assert property (boot_status_oe && !host_accept |-> boot_status_out)
    else $error("status not high during init");
  chk_low_when_done: assert property ($fell(boot_status_out) |-> s_done)
    else $error("status fall without done");
  chk_accept_gate: assert property (host_accept |-> boot_status_oe && !boot_status_out)
    else $error("accept before init done");
  chk_init_time: assert property ($fell(boot_status_out) |-> init_cnt_reg inside {[INIT_CYCLES-1:INIT_CYCLES+1]})
    else $error("init time wrong");
  chk_half_len: assert property ($fell(flash_clk) |-> high_cnt_reg == SLOW_HALF || high_cnt_reg == FAST_HALF)
    else $error("serial clock half period wrong");
  chk_select_one: assert property (flash_select_one_n)
    else $error("select one active");
  chk_load_first: assert property (s_drive_start |-> flash_select_zero_n)
    else $error("init began with flash selected");
  chk_mode0_idle: assert property (flash_select_zero_n |-> !flash_clk)
    else $error("serial clock not idle low");
  chk_dout_clk_low: assert property ($changed(flash_dout) |-> !flash_clk)
    else $error("data out changed with clock high");
endmodule : bfs_checker

bind bfs_top bfs_checker #(.INIT_CYCLES(INIT_CYCLES), .SLOW_HALF(SLOW_HALF), .FAST_HALF(FAST_HALF)) u_chk (
  .sys_clk(sys_clk), .nrst(nrst), .flash_clk(flash_clk), .flash_dout(flash_dout),
  .flash_select_zero_n(flash_select_zero_n), .flash_select_one_n(flash_select_one_n),
  .boot_status_out(boot_status_out), .boot_status_oe(boot_status_oe), .host_accept(host_accept));

// ---- test/bfs_flash_model.sv ----
// behavioural serial flash on select zero
`timescale 1ns/1ns
module bfs_flash_model #(
  parameter int BUSY_POLLS = 3
)(
  input wire logic sck,
  input wire logic sel_n,
  input wire logic mosi,
  output logic miso
);
  // protection starts enabled; busy polls give a slow answer
  logic [7:0] sr_reg = 8'h1c;
  logic [7:0] in_sh;
  logic [7:0] out_sh = 8'h00;
  logic [7:0] cmd;
  logic [23:0] rd_addr;
  logic [7:0] cmds[$];
  int nbit;
  int nbyte;
  int busy = 0;
  time t_rise = 0;
  time first_per = 0;
  time last_per = 0;
  initial miso = 1'b0;
  always @(negedge sel_n)
  begin
    nbit = 0;
    nbyte = 0;
  end
  // a released line must not keep showing the last bit
  always @(posedge sel_n) miso <= ~miso;
  always @(negedge sck)
    if (!sel_n)
    begin
      miso <= out_sh[7];
      out_sh = out_sh << 1;
    end
  always @(posedge sck)
    if (!sel_n)
    begin
      if (nbit > 0)
      begin
        last_per = $time - t_rise;
        if (first_per == 0)
          first_per = last_per;
      end
      t_rise = $time;
      in_sh = {in_sh[6:0], mosi};
      nbit++;
      if (nbit == 8)
      begin
        nbit = 0;
        if (nbyte == 0)
        begin
          cmd = in_sh;
          cmds.push_back(in_sh);
          if (in_sh == 8'h06)
            sr_reg[1] = 1'b1;
        end
        if (nbyte == 1 && cmd == 8'h01 && sr_reg[1])
        begin
          sr_reg = in_sh & 8'hfc;
          busy = BUSY_POLLS;
        end
        if (nbyte inside {[1:3]} && cmd == 8'h0b)
          rd_addr = {rd_addr[15:0], in_sh};
        out_sh = 8'h00;
        if (cmd == 8'h05)
        begin
          out_sh = {sr_reg[7:1], busy > 0};
          if (busy > 0)
            busy--;
        end
        if (cmd == 8'h0b && nbyte >= 4)
          out_sh = 8'(rd_addr + 24'(nbyte - 4)) ^ 8'h5a;
        nbyte++;
      end
    end
endmodule : bfs_flash_model

// ---- test/tb_top.sv ----
// self-checking bench for the boot flash startup sequencer
`timescale 1ns/1ns
module tb_top;
  localparam int INIT = 50;
  localparam int NBYTES = 8;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic flash_clk, flash_dout, flash_din, flash_select_zero_n, flash_select_one_n;
  logic boot_status_out, boot_status_oe, host_accept, boot_error;
  logic [15:0] pmem_raddr = 16'h0000;
  logic [7:0] pmem_rdata;
  logic [31:0] seed = 32'h00000049;
  int num_errors = 0;
  int comparisons = 0;
  always #10 sys_clk = ~sys_clk;
  bfs_top #(.BOOT_BYTES(NBYTES), .INIT_CYCLES(INIT)) dut (.sys_clk(sys_clk), .nrst(nrst),
    .flash_clk(flash_clk), .flash_dout(flash_dout), .flash_din(flash_din),
    .flash_select_zero_n(flash_select_zero_n), .flash_select_one_n(flash_select_one_n),
    .boot_status_out(boot_status_out), .boot_status_oe(boot_status_oe), .pmem_raddr(pmem_raddr),
    .pmem_rdata(pmem_rdata), .host_accept(host_accept), .boot_error(boot_error));
  bfs_flash_model #(.BUSY_POLLS(3)) flash (.sck(flash_clk), .sel_n(flash_select_zero_n),
    .mosi(flash_dout), .miso(flash_din));
  function automatic logic [31:0] next_rand();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : next_rand
  function automatic logic [7:0] boot_byte(input logic [23:0] a);
    return a[7:0] ^ 8'h5a;
  endfunction : boot_byte
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    comparisons++;
    if (seen !== want)
    begin
      num_errors++;
      $display("BAD %0t seen %h want %h", $time, seen, want);
    end
  endtask : check
  task automatic results();
    if (num_errors == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : results
  initial
  begin
    int n;
    logic [15:0] a;
    repeat (20) @(posedge sys_clk);
    check(boot_status_oe, 1'b0);
    check(host_accept, 1'b0);
    nrst <= 1'b1;
    // abort a boot at a random point; the next one must start clean
    repeat (100 + next_rand() % 2000) @(posedge sys_clk);
    nrst <= 1'b0;
    @(posedge sys_clk);
    #1;
    check(boot_status_oe, 1'b0);
    check(flash_select_zero_n, 1'b1);
    flash.sr_reg = 8'h1c;
    flash.first_per = 0;
    flash.cmds.delete();
    @(posedge sys_clk);
    nrst <= 1'b1;
    n = 0;
    while (boot_status_oe !== 1'b1 && n < 40000)
    begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    check(boot_status_oe, 1'b1);
    check(boot_status_out, 1'b1);
    check(host_accept, 1'b0);
    check(flash_select_zero_n, 1'b1);
    check(flash.cmds[0], 8'h06);
    check(flash.sr_reg[6:2], 5'h00);
    check(flash.cmds[flash.cmds.size()-1], 8'h0b);
    check(flash.rd_addr, bfs_pkg::BOOT_ADDR);
    check(32'(flash.first_per), 32'(2 * bfs_pkg::SLOW_HALF * 20));
    check(32'(flash.last_per), 32'(2 * bfs_pkg::FAST_HALF * 20));
    n = 0;
    while (host_accept !== 1'b1 && n < 200)
    begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    check(n inside {[INIT-1:INIT+1]}, 1'b1);
    check({boot_status_oe, boot_status_out}, 2'b10);
    repeat (16)
    begin
      a = 16'(next_rand() % NBYTES);
      @(posedge sys_clk);
      pmem_raddr <= a;
      @(posedge sys_clk);
      @(posedge sys_clk);
      #1;
      check(pmem_rdata, boot_byte(bfs_pkg::BOOT_ADDR + 24'(a)));
    end
    check(boot_error, 1'b0);
    results();
  end
endmodule : tb_top
